/* design/awi_map.vh */
`ifndef AWI_MAP_VH
`define AWI_MAP_VH

`define AWI_ADDR_W          19
`define AWI_ADDR_FLAGS      19'h7FFF0
`define AWI_ADDR_ALM_SEC    19'h7FFF2
`define AWI_ADDR_ALM_MIN    19'h7FFF3
`define AWI_ADDR_ALM_HOUR   19'h7FFF4
`define AWI_ADDR_ALM_DATE   19'h7FFF5
`define AWI_ADDR_INTR       19'h7FFF6
`define AWI_ADDR_WDOG       19'h7FFF7

`define AWI_FLAGS_WF        7
`define AWI_FLAGS_AF        6
`define AWI_FLAGS_BLF       4
`define AWI_INTR_AE         7
`define AWI_INTR_ABE        5
`define AWI_ALM_MASK        7
`define AWI_WDOG_WDS        7
`define AWI_WDOG_MULT_HI    6
`define AWI_WDOG_MULT_LO    2
`define AWI_WDOG_RES_HI     1
`define AWI_WDOG_RES_LO     0

`define AWI_WDOG_RST        8'h00
`define AWI_INTR_RST        8'h00
`define AWI_ALM_RST         8'h00

`define AWI_RES_16TH        2'h0
`define AWI_RES_QUARTER     2'h1
`define AWI_RES_ONE         2'h2
`define AWI_RES_FOUR        2'h3

`define AWI_TICKS_16TH      2048
`define AWI_TICKS_QUARTER   8192
`define AWI_TICKS_ONE       32768
`define AWI_TICKS_FOUR      131072

`define AWI_MODE_EVERY_SEC  4'hF
`define AWI_MODE_SEC        4'hE
`define AWI_MODE_MIN_SEC    4'hC
`define AWI_MODE_HMS        4'h8
`define AWI_MODE_DHMS       4'h0

`define AWI_CLK_PERIOD_NS   5
`define AWI_ADDR_STABLE_NS  15
`define AWI_ADDR_STABLE_CYC ((`AWI_ADDR_STABLE_NS + `AWI_CLK_PERIOD_NS - 1) / `AWI_CLK_PERIOD_NS)

`endif

/* design/awi_top.v */
// What this block does
// - Alarm flag set on masked time match
// - Enabled alarm flag drives interrupt low
// - Flags access releases alarm interrupt
// - Flags access clears alarm flag at end
// - On battery, needs both enables
// - Power-up clears enables, match still flags
// - Watchdog register: steering, multiplier, resolution
// - Resolution selects 1/16, 1/4, 1, 4 s
// - Timeout equals multiplier times unit
// - Timeout sets flag, interrupt until cleared
// - Steering zero routes timeout to interrupt
// - Watchdog register access restarts countdown
// - Writing zero disables the watchdog
// - Reset clears whole watchdog register
// - Reset zeroes steering, timeout, alarm enables
// - Mask bits pick alarm match mode
// - Undefined mask codes alarm every second
// - Both alarm enables in interrupts register
`timescale 1ns/1ps
`include "awi_map.vh"

module awi_top #(
  parameter TICKS_16TH    = `AWI_TICKS_16TH,
  parameter TICKS_QUARTER = `AWI_TICKS_QUARTER,
  parameter TICKS_ONE     = `AWI_TICKS_ONE,
  parameter TICKS_FOUR    = `AWI_TICKS_FOUR
) (
  input  wire                   clock,
  input  wire                   srst,
  input  wire                   ce_n,
  input  wire                   oe_n,
  input  wire                   we_n,
  input  wire [`AWI_ADDR_W-1:0] addr,
  input  wire [7:0]             dq_in,
  output wire [7:0]             dq_out,
  output wire                   dq_oe,
  input  wire                   osc_32k,
  input  wire                   on_battery,
  input  wire                   power_up,
  input  wire                   battery_low,
  input  wire                   sec_tick,
  input  wire [6:0]             cur_seconds,
  input  wire [6:0]             cur_minutes,
  input  wire [5:0]             cur_hours,
  input  wire [5:0]             cur_date,
  output wire                   interrupt_out_n_o,
  output wire                   interrupt_out_n_oe
);

  localparam SW = 3 + `AWI_ADDR_W + 8 + 4;
  localparam integer STABLE_I   = `AWI_ADDR_STABLE_CYC;
  localparam [1:0]   STABLE_CYC = STABLE_I[1:0];

  // Pin synchronisers, all asynchronous inputs together
  reg  [SW-1:0] sync1_r;
  reg  [SW-1:0] sync2_r;
  wire          ce_n_s;
  wire          oe_n_s;
  wire          we_n_s;
  wire [`AWI_ADDR_W-1:0] addr_s;
  wire [7:0]    dq_s;
  wire          osc_s;
  wire          batt_s;
  wire          pwrup_s;
  wire          blf_s;

  always @(posedge clock)
  begin
    sync1_r <= {ce_n, oe_n, we_n, addr, dq_in,
                osc_32k, on_battery, power_up, battery_low};
    sync2_r <= sync1_r;
  end

  assign {ce_n_s, oe_n_s, we_n_s, addr_s, dq_s,
          osc_s, batt_s, pwrup_s, blf_s} = sync2_r;

  // Oscillator edge gives one tick per 32.768kHz period
  reg  osc_d_r;
  wire osc_tick;

  always @(posedge clock)
  begin
    if (srst)
      osc_d_r <= 1'b0;
    else
      osc_d_r <= osc_s;
  end

  assign osc_tick = osc_s & ~osc_d_r;

  // Registers
  reg [7:0] alm_sec_r;
  reg [7:0] alm_min_r;
  reg [7:0] alm_hour_r;
  reg [7:0] alm_date_r;
  reg [7:0] intr_r;
  reg [7:0] wdog_r;
  reg       alarm_flag_r;
  reg       watchdog_flag_r;
  reg       alarm_irq_r;
  reg       wdog_irq_r;
  reg [7:0] dq_out_r;

  wire alarm_irq_enable    = intr_r[`AWI_INTR_AE];
  wire backup_alarm_enable = intr_r[`AWI_INTR_ABE];
  wire watchdog_steering   = wdog_r[`AWI_WDOG_WDS];
  wire [4:0] timeout_multiplier =
    wdog_r[`AWI_WDOG_MULT_HI:`AWI_WDOG_MULT_LO];
  wire [1:0] timeout_resolution =
    wdog_r[`AWI_WDOG_RES_HI:`AWI_WDOG_RES_LO];

  // Bus access: address must sit still a few cycles first,
  // so a sliding address does not hit a neighbour register
  reg [`AWI_ADDR_W-1:0] addr_d_r;
  reg [1:0]             stable_r;
  reg                   acc_r;
  reg [`AWI_ADDR_W-1:0] acc_addr_r;
  reg [7:0]             acc_data_r;
  reg                   acc_wr_r;
  wire                  strobe;
  wire                  acc_on;
  wire                  acc_end;

  assign strobe  = ~ce_n_s & (~oe_n_s | ~we_n_s);
  assign acc_on  = strobe & (stable_r == STABLE_CYC);
  assign acc_end = acc_r & ~strobe;

  always @(posedge clock)
  begin
    if (srst)
    begin
      addr_d_r <= {`AWI_ADDR_W{1'b0}};
      stable_r <= 2'h0;
    end
    else
    begin
      addr_d_r <= addr_s;
      if (addr_s != addr_d_r)
        stable_r <= 2'h0;
      else if (stable_r != STABLE_CYC)
        stable_r <= stable_r + 2'h1;
    end
  end

  // Keep the last qualified address and data for the end of cycle
  always @(posedge clock)
  begin
    if (srst)
    begin
      acc_r      <= 1'b0;
      acc_addr_r <= {`AWI_ADDR_W{1'b0}};
      acc_data_r <= 8'h00;
      acc_wr_r   <= 1'b0;
    end
    else
    begin
      if (acc_on)
      begin
        acc_r      <= 1'b1;
        acc_addr_r <= addr_s;
        acc_data_r <= dq_s;
        acc_wr_r   <= ~we_n_s;
      end
      else if (!strobe)
        acc_r <= 1'b0;
    end
  end

  function hit;
    input [`AWI_ADDR_W-1:0] a;
    input [`AWI_ADDR_W-1:0] target;
    begin
      hit = (a == target);
    end
  endfunction

  wire flags_live = acc_on & hit(addr_s, `AWI_ADDR_FLAGS);
  wire wdog_live  = acc_on & hit(addr_s, `AWI_ADDR_WDOG);
  wire flags_end  = acc_end & hit(acc_addr_r, `AWI_ADDR_FLAGS);
  wire wdog_end   = acc_end & hit(acc_addr_r, `AWI_ADDR_WDOG);
  wire wr_end     = acc_end & acc_wr_r;

  // Alarm match
  function match_hit;
    input [3:0] mask;
    input       s_eq;
    input       m_eq;
    input       h_eq;
    input       d_eq;
    begin
      case (mask)
        `AWI_MODE_SEC:     match_hit = s_eq;
        `AWI_MODE_MIN_SEC: match_hit = s_eq & m_eq;
        `AWI_MODE_HMS:     match_hit = s_eq & m_eq & h_eq;
        `AWI_MODE_DHMS:    match_hit = s_eq & m_eq & h_eq & d_eq;
        default:           match_hit = 1'b1;
      endcase
    end
  endfunction

  wire [3:0] alarm_mask_bits = {alm_date_r[`AWI_ALM_MASK],
                                alm_hour_r[`AWI_ALM_MASK],
                                alm_min_r[`AWI_ALM_MASK],
                                alm_sec_r[`AWI_ALM_MASK]};
  wire alarm_event = sec_tick & match_hit(alarm_mask_bits,
                       cur_seconds == alm_sec_r[6:0],
                       cur_minutes == alm_min_r[6:0],
                       cur_hours   == alm_hour_r[5:0],
                       cur_date    == alm_date_r[5:0]);

  // Battery mode also demands the backup enable
  wire alarm_irq_set = alarm_event & alarm_irq_enable &
                       (~batt_s | backup_alarm_enable);
  wire wdog_timeout;
  awi_wdog #(
    .TICKS0 (TICKS_16TH),
    .TICKS1 (TICKS_QUARTER),
    .TICKS2 (TICKS_ONE),
    .TICKS3 (TICKS_FOUR),
    .PW     (17)
  ) u_wdog (
    .clock      (clock),
    .srst       (srst),
    .osc_tick   (osc_tick),
    .restart    (wdog_end),
    .multiplier (timeout_multiplier),
    .resolution (timeout_resolution),
    .timeout    (wdog_timeout)
  );

  // Flags: hardware set wins over any clear in the same cycle
  always @(posedge clock)
  begin
    if (srst)
    begin
      alarm_flag_r    <= 1'b0;
      watchdog_flag_r <= 1'b0;
      alarm_irq_r     <= 1'b0;
      wdog_irq_r      <= 1'b0;
    end
    else
    begin
      // Power-up does not block the flag, only the enables
      if (alarm_event)
        alarm_flag_r <= 1'b1;
      else if (flags_end)
        alarm_flag_r <= 1'b0;
      if (wdog_timeout)
        watchdog_flag_r <= 1'b1;
      else if (flags_end || wdog_end)
        watchdog_flag_r <= 1'b0;
      // Released at once, before the flag itself drops
      if (alarm_irq_set)
        alarm_irq_r <= 1'b1;
      else if (flags_live)
        alarm_irq_r <= 1'b0;
      if (wdog_timeout && !watchdog_steering)
        wdog_irq_r <= 1'b1;
      else if (flags_live || wdog_live)
        wdog_irq_r <= 1'b0;
    end
  end

  // Register writes commit at the end of the bus cycle
  always @(posedge clock)
  begin
    if (srst)
    begin
      alm_sec_r  <= `AWI_ALM_RST;
      alm_min_r  <= `AWI_ALM_RST;
      alm_hour_r <= `AWI_ALM_RST;
      alm_date_r <= `AWI_ALM_RST;
      intr_r     <= `AWI_INTR_RST;
      wdog_r     <= `AWI_WDOG_RST;
    end
    else
    begin
      if (wr_end && hit(acc_addr_r, `AWI_ADDR_ALM_SEC))
        alm_sec_r <= acc_data_r;
      if (wr_end && hit(acc_addr_r, `AWI_ADDR_ALM_MIN))
        alm_min_r <= acc_data_r;
      if (wr_end && hit(acc_addr_r, `AWI_ADDR_ALM_HOUR))
        alm_hour_r <= acc_data_r;
      if (wr_end && hit(acc_addr_r, `AWI_ADDR_ALM_DATE))
        alm_date_r <= acc_data_r;
      if (wr_end && hit(acc_addr_r, `AWI_ADDR_WDOG))
        wdog_r <= acc_data_r;
      if (pwrup_s)
      begin
        intr_r[`AWI_INTR_AE]  <= 1'b0;
        intr_r[`AWI_INTR_ABE] <= 1'b0;
      end
      else if (wr_end && hit(acc_addr_r, `AWI_ADDR_INTR))
        intr_r <= acc_data_r;
    end
  end

  // Read path
  wire [7:0] flags_view = {watchdog_flag_r, alarm_flag_r, 1'b0,
                           blf_s, 4'h0};
  reg  [7:0] rd_mux;
  reg        rd_hit;

  always @*
  begin
    rd_hit = 1'b1;
    case (addr_s)
      `AWI_ADDR_FLAGS:    rd_mux = flags_view;
      `AWI_ADDR_ALM_SEC:  rd_mux = alm_sec_r;
      `AWI_ADDR_ALM_MIN:  rd_mux = alm_min_r;
      `AWI_ADDR_ALM_HOUR: rd_mux = alm_hour_r;
      `AWI_ADDR_ALM_DATE: rd_mux = alm_date_r;
      `AWI_ADDR_INTR:     rd_mux = intr_r;
      `AWI_ADDR_WDOG:     rd_mux = wdog_r;
      default:
      begin
        rd_mux = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
  end

  always @(posedge clock)
  begin
    if (srst)
      dq_out_r <= 8'h00;
    else
      dq_out_r <= rd_mux;
  end
  // Other addresses belong to the RAM, so stay off the bus
  assign dq_out = dq_out_r;
  assign dq_oe  = ~ce_n_s & ~oe_n_s & we_n_s & rd_hit;
  // Open-drain: pull low while either source is pending
  assign interrupt_out_n_o  = 1'b0;
  assign interrupt_out_n_oe = alarm_irq_r | wdog_irq_r;

endmodule

/* design/awi_wdog.v */
`timescale 1ns/1ps
`include "awi_map.vh"

module awi_wdog #(
  parameter TICKS0 = `AWI_TICKS_16TH,
  parameter TICKS1 = `AWI_TICKS_QUARTER,
  parameter TICKS2 = `AWI_TICKS_ONE,
  parameter TICKS3 = `AWI_TICKS_FOUR,
  parameter PW     = 17
) (
  input  wire       clock,
  input  wire       srst,
  input  wire       osc_tick,
  input  wire       restart,
  input  wire [4:0] multiplier,
  input  wire [1:0] resolution,
  output wire       timeout
);

  // Integer sums cut to counter width on purpose
  localparam integer  LIM0_I = TICKS0 - 1;
  localparam integer  LIM1_I = TICKS1 - 1;
  localparam integer  LIM2_I = TICKS2 - 1;
  localparam integer  LIM3_I = TICKS3 - 1;
  localparam [PW-1:0] LIM0   = LIM0_I[PW-1:0];
  localparam [PW-1:0] LIM1   = LIM1_I[PW-1:0];
  localparam [PW-1:0] LIM2   = LIM2_I[PW-1:0];
  localparam [PW-1:0] LIM3   = LIM3_I[PW-1:0];

  reg [PW-1:0] pre_r;
  reg [4:0]    units_r;
  reg          timeout_r;
  wire [PW-1:0] lim;

  function [PW-1:0] unit_limit;
    input [1:0] res;
    begin
      case (res)
        `AWI_RES_16TH:    unit_limit = LIM0;
        `AWI_RES_QUARTER: unit_limit = LIM1;
        `AWI_RES_ONE:     unit_limit = LIM2;
        default:          unit_limit = LIM3;
      endcase
    end
  endfunction

  assign lim     = unit_limit(resolution);
  assign timeout = timeout_r;

  always @(posedge clock)
  begin
    if (srst || restart || multiplier == 5'h00)
    begin
      pre_r     <= {PW{1'b0}};
      units_r   <= 5'h00;
      timeout_r <= 1'b0;
    end
    else
    begin
      timeout_r <= 1'b0;
      if (osc_tick)
      begin
        if (pre_r == lim)
        begin
          pre_r <= {PW{1'b0}};
          // Period is multiplier whole units
          if (units_r == multiplier - 5'h01)
          begin
            units_r   <= 5'h00;
            timeout_r <= 1'b1;
          end
          else
            units_r <= units_r + 5'h01;
        end
        else
          pre_r <= pre_r + {{(PW-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule

/* sim/awi_host.sv */
`timescale 1ns/1ps
`include "awi_map.vh"
module awi_host (
  input  wire                   clock,
  input  wire [7:0]             dq_out,
  input  wire                   dq_oe,
  output reg                    ce_n,
  output reg                    oe_n,
  output reg                    we_n,
  output reg  [`AWI_ADDR_W-1:0] addr,
  output reg  [7:0]             dq_in
);
  initial
  begin
    ce_n = 1'b1;
    oe_n = 1'b1;
    we_n = 1'b1;
    addr = 19'h00000;
    dq_in = 8'h00;
  end
  // Held 8 cycles so the 3-cycle address window always qualifies
  task acc(input wr, input [18:0] a, input [7:0] d, output [7:0] q,
    output drv);
  begin
    if (wr && a == `AWI_ADDR_WDOG)
      d[7] = 1'b0;
    @(posedge clock);
    #1 addr = a;
    dq_in = d;
    ce_n = 1'b0;
    oe_n = wr;
    we_n = !wr;
    repeat (8) @(posedge clock);
    // Sampled just after the edge, once dq_out has settled
    #1 q = dq_out;
    drv = dq_oe;
    ce_n = 1'b1;
    oe_n = 1'b1;
    we_n = 1'b1;
    addr = ~a; // Released lines never keep the old value
    dq_in = ~d;
    repeat (4) @(posedge clock);
    #1;
  end
  endtask
endmodule

/* sim/awi_props.sv */
`timescale 1ns/1ps
`include "awi_map.vh"
module awi_props (
  input wire                   clock,
  input wire                   srst,
  input wire                   ce_n,
  input wire                   oe_n,
  input wire                   we_n,
  input wire [`AWI_ADDR_W-1:0] addr,
  input wire                   sec_tick,
  input wire                   dq_oe,
  input wire                   interrupt_out_n_o,
  input wire                   interrupt_out_n_oe
);
  wire rd_q = !ce_n && !oe_n && we_n;
  wire flg  = addr == `AWI_ADDR_FLAGS;
  wire ours = flg || addr == `AWI_ADDR_WDOG;
  default clocking @(posedge clock);
  endclocking
  default disable iff (srst);
  a_pin_low:
    assert property (interrupt_out_n_o == 1'b0)
    else $error("irq data not low");
  a_reset_clear:
    assert property (disable iff (1'b0) srst |=> !interrupt_out_n_oe)
    else $error("irq after reset");
  a_read_drives:
    assert property ((rd_q && ours) [*3] |-> dq_oe)
    else $error("no drive on read");
  a_bad_addr:
    assert property ((rd_q && addr == 19'h7FFF1) [*3] |-> !dq_oe)
    else $error("drive on unmapped");
  a_idle_quiet:
    assert property (ce_n [*3] |-> !dq_oe)
    else $error("drive while idle");
  a_write_quiet:
    assert property ((!we_n) [*3] |-> !dq_oe)
    else $error("drive on write");
  a_flags_release:
    assert property ((rd_q && flg && !sec_tick) [*8] |-> !interrupt_out_n_oe)
    else $error("irq held over flags read");
  a_irq_holds:
    assert property ((ce_n [*3] ##0 interrupt_out_n_oe) |=> interrupt_out_n_oe)
    else $error("irq dropped without access");
  c_irq: cover property ($rose(interrupt_out_n_oe));
  c_flags: cover property ((rd_q && flg) [*8]);
  c_write: cover property ((!ce_n && !we_n) [*8]);
endmodule
bind awi_top awi_props u_props (.clock(clock), .srst(srst), .ce_n(ce_n),
  .oe_n(oe_n), .we_n(we_n), .addr(addr), .sec_tick(sec_tick), .dq_oe(dq_oe),
  .interrupt_out_n_o(interrupt_out_n_o),
  .interrupt_out_n_oe(interrupt_out_n_oe));

/* sim/testbench.sv */
`timescale 1ns/1ps
`include "awi_map.vh"
module testbench;
  reg                    clock;
  reg                    srst;
  reg                    on_battery;
  reg                    power_up;
  reg                    sec_tick;
  reg  [6:0]             cur_seconds;
  reg  [5:0]             cur_date;
  reg                    battery_low;
  reg  [6:0]             cur_minutes;
  reg  [5:0]             cur_hours;
  reg  [2:0]             osc_cnt = 3'h0;
  wire                   ce_n;
  wire                   oe_n;
  wire                   we_n;
  wire [`AWI_ADDR_W-1:0] addr;
  wire [7:0]             dq_in;
  wire [7:0]             dq_out;
  wire                   dq_oe;
  wire                   irq_oe;
  integer                fails;
  integer                checks_done;
  awi_top #(.TICKS_16TH(4), .TICKS_QUARTER(8), .TICKS_ONE(16),
    .TICKS_FOUR(32)) uut (.clock(clock), .srst(srst), .ce_n(ce_n),
    .oe_n(oe_n), .we_n(we_n), .addr(addr), .dq_in(dq_in), .dq_out(dq_out),
    .dq_oe(dq_oe), .osc_32k(osc_cnt[2]), .on_battery(on_battery),
    .power_up(power_up), .battery_low(battery_low), .sec_tick(sec_tick),
    .cur_seconds(cur_seconds), .cur_minutes(cur_minutes),
    .cur_hours(cur_hours), .cur_date(cur_date), .interrupt_out_n_o(),
    .interrupt_out_n_oe(irq_oe));
  awi_host host (.clock(clock), .dq_out(dq_out), .dq_oe(dq_oe),
    .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(addr), .dq_in(dq_in));
  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // Oscillator at one eighth of the clock keeps timeouts short
  always @(posedge clock)
    #1 osc_cnt = osc_cnt + 3'h1;
  task give_verdict;
  begin
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  end
  endtask
  task chk(input [7:0] g, input [7:0] e, input [63:0] m);
  begin
    checks_done = checks_done + 1;
    if (g !== e)
    begin
      fails = fails + 1;
      $display("MISMATCH %0t %0s got %h exp %h", $time, m, g, e);
    end
  end
  endtask
  task rd(input [18:0] a, input [7:0] e);
    reg [7:0] q;
    reg       d;
  begin
    host.acc(1'b0, a, 8'h00, q, d);
    chk(q, e, "read");
    chk({7'h00, d}, 8'h01, "drive");
  end
  endtask
  task wr(input [18:0] a, input [7:0] v);
    reg [7:0] q;
    reg       d;
  begin
    host.acc(1'b1, a, v, q, d);
  end
  endtask
  task set_mode(input [3:0] m, input [7:0] en);
  begin
    wr(`AWI_ADDR_ALM_SEC, {m[0], 7'h30});
    wr(`AWI_ADDR_ALM_MIN, {m[1], 7'h15});
    wr(`AWI_ADDR_ALM_HOUR, {m[2], 7'h08});
    wr(`AWI_ADDR_ALM_DATE, {m[3], 7'h12});
    wr(`AWI_ADDR_INTR, en);
  end
  endtask
  task tick(input sd, input dd, input ei, input [7:0] ef);
  begin
    cur_seconds = sd ? 7'h31 : 7'h30;
    cur_date = dd ? 6'h13 : 6'h12;
    sec_tick = 1'b1;
    @(posedge clock);
    #1 sec_tick = 1'b0;
    chk({7'h00, irq_oe}, {7'h00, ei}, "alm irq");
    rd(`AWI_ADDR_FLAGS, ef);
    chk({7'h00, irq_oe}, 8'h00, "irq clr");
  end
  endtask
  task wd_wait(input integer e);
    integer n;
  begin
    n = 0;
    while (irq_oe !== 1'b1 && n < 2000)
    begin
      @(posedge clock);
      #1 n = n + 1;
    end
    chk({7'h00, n >= e - 10 && n <= e + 5}, 8'h01, "wd time");
    rd(`AWI_ADDR_FLAGS, 8'h80);
    chk({7'h00, irq_oe}, 8'h00, "wd clr");
  end
  endtask
  task t_reset;
    reg [7:0] q;
    reg       d;
  begin
    chk({7'h00, irq_oe}, 8'h00, "rst irq");
    rd(`AWI_ADDR_WDOG, 8'h00);
    rd(`AWI_ADDR_INTR, 8'h00);
    host.acc(1'b0, 19'h7FFF1, 8'h00, q, d);
    chk({7'h00, d}, 8'h00, "unmapped");
  end
  endtask
  task t_modes;
    reg [23:0] tbl;
    reg [3:0]  m;
    reg        f;
    integer    i;
  begin
    tbl = 24'hFEC80A;
    for (i = 0; i < 6; i = i + 1)
    begin
      m = tbl[4 * (5 - i) +: 4];
      f = (m == 4'hF) || (m == 4'hA);
      set_mode(m, 8'h80);
      tick(1'b0, 1'b1, m != 4'h0, (m != 4'h0) ? 8'h40 : 8'h00);
      tick(1'b1, 1'b0, f, f ? 8'h40 : 8'h00);
      cur_minutes = 7'h16;
      tick(1'b0, 1'b0, m[1], m[1] ? 8'h40 : 8'h00);
      cur_minutes = 7'h15;
      cur_hours = 6'h09;
      f = m[2] || (m == 4'hA);
      tick(1'b0, 1'b0, f, f ? 8'h40 : 8'h00);
      cur_hours = 6'h08;
    end
    set_mode(4'h0, 8'h80);
    tick(1'b0, 1'b0, 1'b1, 8'h40);
  end
  endtask
  task t_batt;
  begin
    on_battery = 1'b1;
    battery_low = 1'b1;
    set_mode(4'hF, 8'h80);
    tick(1'b0, 1'b0, 1'b0, 8'h50);
    wr(`AWI_ADDR_INTR, 8'hA0);
    tick(1'b0, 1'b0, 1'b1, 8'h50);
    on_battery = 1'b0;
    battery_low = 1'b0;
  end
  endtask
  task t_flagwr;
  begin
    sec_tick = 1'b1;
    @(posedge clock);
    #1 sec_tick = 1'b0;
    chk({7'h00, irq_oe}, 8'h01, "alm irq");
    wr(`AWI_ADDR_FLAGS, 8'h00);
    chk({7'h00, irq_oe}, 8'h00, "wr clr");
    rd(`AWI_ADDR_FLAGS, 8'h00);
  end
  endtask
  task t_pwr;
  begin
    wr(`AWI_ADDR_INTR, 8'hA0);
    power_up = 1'b1;
    repeat (4) @(posedge clock);
    #1 tick(1'b0, 1'b0, 1'b0, 8'h40);
    power_up = 1'b0;
    rd(`AWI_ADDR_INTR, 8'h00);
  end
  endtask
  task t_wd;
    integer r;
  begin
    for (r = 0; r < 4; r = r + 1)
    begin
      wr(`AWI_ADDR_WDOG, 8'h08 | r[7:0]);
      wd_wait(64 << r);
      wr(`AWI_ADDR_WDOG, 8'h00);
    end
  end
  endtask
  task t_restart;
    reg     seen;
    integer n;
  begin
    wr(`AWI_ADDR_WDOG, 8'h0C);
    repeat (60) @(posedge clock);
    #1 rd(`AWI_ADDR_WDOG, 8'h0C);
    wd_wait(96);
    wr(`AWI_ADDR_WDOG, 8'h00);
    seen = 1'b0;
    for (n = 0; n < 700; n = n + 1)
    begin
      @(posedge clock);
      #1 seen = seen | irq_oe;
    end
    chk({7'h00, seen}, 8'h00, "wd off");
  end
  endtask
  initial
  begin
    repeat (20000) @(posedge clock);
    fails = fails + 1;
    give_verdict;
  end
  initial
  begin
    srst = 1'b1;
    on_battery = 1'b0;
    power_up = 1'b0;
    sec_tick = 1'b0;
    cur_seconds = 7'h00;
    cur_date = 6'h00;
    battery_low = 1'b0;
    cur_minutes = 7'h15;
    cur_hours = 6'h08;
    fails = 0;
    checks_done = 0;
    repeat (20) @(posedge clock);
    #1 srst = 1'b0;
    t_reset;
    t_modes;
    t_flagwr;
    t_batt;
    t_pwr;
    t_wd;
    t_restart;
    give_verdict;
  end
endmodule
